// file: rtl/adcc_ctrl.sv
`timescale 1ns/10ps
module adcc_ctrl
    import adcc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire adcc_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    input wire logic prot_lock_i,
    input wire logic standby_i,
    input wire logic start_i,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    input wire logic [11:0] gain_corr_i,
    input wire logic [11:0] offset_corr_i,
    output logic sync_busy_o,
    output logic enabled_o,
    output logic sample_o,
    output logic conv_start_o,
    output adcc_core_cfg_t core_cfg_o,
    output logic [15:0] result_o,
    output logic result_valid_o
);

    logic run_stby_reg, enable_reg, enable_act_reg, soft_reset_bit_reg;
    logic [7:0] ref_reg, avg_reg, samp_reg, conv_lo_reg, conv_hi_reg;
    logic [7:0] conv_lo_act_reg, conv_hi_act_reg;
    logic [2:0] sync_cnt_reg;
    logic hold_v_reg;
    adcc_bus_req_t hold_reg, ew;
    logic stby_meta_reg, stby_reg;
    logic busy, rel, take, touch_sync, wr_ok, soft_reset_bit_wr, gen_wr;
    logic sync_start, sync_done, soft_clear, clr, conv_wr_ok;
    logic [7:0] main_wb;

    // true when byte register off is covered by request r
    function automatic logic wr_hit(input adcc_bus_req_t r,
                                    input logic [5:0] off);
        logic [5:0] d;
        d = off - r.addr;
        return r.wr && (d < (6'h01 << r.size));
    endfunction : wr_hit

    // data lane that lands on byte register off
    function automatic logic [7:0] wr_byte(input adcc_bus_req_t r,
                                           input logic [5:0] off);
        logic [5:0] d;
        d = off - r.addr;
        return r.wdata[{d[1:0], 3'b000} +: 8];
    endfunction : wr_byte

    // sync arbitration: a synced write seen while busy waits in hold
    always_comb
    begin
        touch_sync = wr_hit(bus_i, OFF_MAIN) || wr_hit(bus_i, OFF_CONV_LO)
                     || wr_hit(bus_i, OFF_CONV_HI);
        busy = (sync_cnt_reg != 3'h0) || hold_v_reg;
        rel = hold_v_reg && (sync_cnt_reg == 3'h0);
        take = bus_i.wr && ((busy && touch_sync) || rel);
        ew = '0;
        if (rel)
            ew = hold_reg;
        else if (bus_i.wr && !take)
            ew = bus_i;
        wr_ok = ew.wr && !prot_lock_i;
        main_wb = wr_byte(ew, OFF_MAIN);
        soft_reset_bit_wr = wr_ok && wr_hit(ew, OFF_MAIN) && main_wb[MAIN_SOFT_RESET_BIT];
        gen_wr = wr_ok && !soft_reset_bit_wr;
        sync_start = wr_ok && (wr_hit(ew, OFF_MAIN)
                     || wr_hit(ew, OFF_CONV_LO) || wr_hit(ew, OFF_CONV_HI));
        sync_done = (sync_cnt_reg == 3'h1);
        soft_clear = sync_done && soft_reset_bit_reg;
        clr = !resetn_i || soft_clear;
        conv_wr_ok = !enable_reg && !enable_act_reg;
    end

    // one-deep hold so the master is never stalled
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            hold_v_reg <= 1'b0;
            hold_reg <= '0;
        end
        else if (take)
        begin
            hold_v_reg <= 1'b1;
            hold_reg <= bus_i;
        end
        else if (rel)
            hold_v_reg <= 1'b0;
    end

    // fixed-latency handover into the converter side
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            sync_cnt_reg <= 3'h0;
        else if (sync_start)
            sync_cnt_reg <= SYNC_CYCLES;
        else if (sync_cnt_reg != 3'h0)
            sync_cnt_reg <= sync_cnt_reg - 3'h1;
    end

    // main control and software-visible configuration
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            run_stby_reg <= 1'b0;
            enable_reg <= 1'b0;
            soft_reset_bit_reg <= 1'b0;
            ref_reg <= REG_RESET;
            avg_reg <= REG_RESET;
            samp_reg <= REG_RESET;
            conv_lo_reg <= REG_RESET;
            conv_hi_reg <= REG_RESET;
        end
        else if (soft_reset_bit_wr)
            soft_reset_bit_reg <= 1'b1;
        else if (gen_wr)
        begin
            if (wr_hit(ew, OFF_MAIN))
            begin
                run_stby_reg <= main_wb[MAIN_RUNSTBY];
                enable_reg <= main_wb[MAIN_ENABLE];
            end
            if (wr_hit(ew, OFF_REF))
                ref_reg <= wr_byte(ew, OFF_REF) & REF_MASK;
            if (wr_hit(ew, OFF_AVG))
                avg_reg <= wr_byte(ew, OFF_AVG) & AVG_MASK;
            if (wr_hit(ew, OFF_SAMP))
                samp_reg <= wr_byte(ew, OFF_SAMP) & SAMP_MASK;
            if (wr_hit(ew, OFF_CONV_LO) && conv_wr_ok)
                conv_lo_reg <= wr_byte(ew, OFF_CONV_LO) & CONV_LO_MASK;
            if (wr_hit(ew, OFF_CONV_HI) && conv_wr_ok)
                conv_hi_reg <= wr_byte(ew, OFF_CONV_HI) & CONV_HI_MASK;
        end
    end

    // values the converter really uses, updated only at sync end
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            enable_act_reg <= 1'b0;
            conv_lo_act_reg <= REG_RESET;
            conv_hi_act_reg <= REG_RESET;
        end
        else if (sync_done)
        begin
            enable_act_reg <= enable_reg;
            conv_lo_act_reg <= conv_lo_reg;
            conv_hi_act_reg <= conv_hi_reg;
        end
    end

    // register read map, unmapped bytes read zero
    function automatic logic [7:0] rd_byte(input logic [5:0] a);
        unique case (a)
            OFF_MAIN: rd_byte = {5'h00, run_stby_reg, enable_reg,
                                 soft_reset_bit_reg};
            OFF_REF: rd_byte = ref_reg;
            OFF_AVG: rd_byte = avg_reg;
            OFF_SAMP: rd_byte = samp_reg;
            OFF_CONV_LO: rd_byte = conv_lo_reg;
            OFF_CONV_HI: rd_byte = conv_hi_reg;
            OFF_STATUS: rd_byte = {busy, 7'h00};
            default: rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    // read data stand exactly one cycle after the strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            rdata_o <= 32'h0000_0000;
        else if (bus_i.rd)
        begin
            for (int k = 0; k < 4; k++)
                rdata_o[8*k +: 8] <= (k < (1 << bus_i.size)) ?
                    rd_byte(bus_i.addr + 6'(k)) : 8'h00;
        end
        else
            rdata_o <= 32'h0000_0000;
    end

    // standby comes from the power domain, two flops before use
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            stby_meta_reg <= 1'b0;
            stby_reg <= 1'b0;
        end
        else
        begin
            stby_meta_reg <= standby_i;
            stby_reg <= stby_meta_reg;
        end
    end

    // converter side
    adcc_state_t state_reg;
    logic running, htick;
    logic [8:0] presc_cnt_reg, presc_last, half_mask;
    logic [5:0] samp_cnt_reg;
    logic [10:0] n_cnt_reg, n_last;
    logic [21:0] acc_reg, acc_sum;
    logic [3:0] extra_reg, num_eff;
    logic [15:0] avg16, corr16, fmt16;
    logic signed [17:0] diff_s;
    logic signed [30:0] prod_s, scaled_s;

    always_comb
    begin
        running = enable_act_reg && !(stby_reg && !run_stby_reg);
        presc_last = (PRESC_BASE << conv_hi_act_reg[2:0]) - 9'h001;
        half_mask = (HALF_BASE << conv_hi_act_reg[2:0]) - 9'h001;
        htick = (presc_cnt_reg & half_mask) == half_mask;
        num_eff = (avg_reg[AVG_NUM_LSB +: 4] > AVG_NUM_MAX) ?
                  AVG_NUM_MAX : avg_reg[AVG_NUM_LSB +: 4];
        n_last = (11'h001 << num_eff) - 11'h001;
        acc_sum = acc_reg + {10'h000, conv_data_i};
    end

    // converter clock prescaler, restarted for each sampling window so
    // every window is whole half-periods long, not cut by a stale phase
    always_ff @(posedge sys_clk_i)
    begin
        if (clr || !running || state_reg != ST_SAMPLE)
            presc_cnt_reg <= 9'h000;
        else if (presc_cnt_reg == presc_last)
            presc_cnt_reg <= 9'h000;
        else
            presc_cnt_reg <= presc_cnt_reg + 9'h001;
    end

    // sample, convert, accumulate, correct
    always_ff @(posedge sys_clk_i)
    begin
        if (clr || !running)
        begin
            state_reg <= ST_IDLE;
            samp_cnt_reg <= 6'h00;
            n_cnt_reg <= 11'h000;
            acc_reg <= 22'h000000;
            extra_reg <= 4'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (start_i)
                    begin
                        state_reg <= ST_SAMPLE;
                        samp_cnt_reg <= 6'h00;
                        n_cnt_reg <= 11'h000;
                        acc_reg <= 22'h000000;
                    end
                ST_SAMPLE:
                    if (htick)
                    begin
                        if (samp_cnt_reg == samp_reg[5:0])
                            state_reg <= ST_CONVERT;
                        else
                            samp_cnt_reg <= samp_cnt_reg + 6'h01;
                    end
                ST_CONVERT:
                    if (conv_done_i)
                    begin
                        acc_reg <= acc_sum;
                        samp_cnt_reg <= 6'h00;
                        if (n_cnt_reg == n_last)
                        begin
                            state_reg <= ST_CORRECT;
                            extra_reg <= conv_lo_act_reg[CONV_CORR] ?
                                offset_corr_i[3:0] : 4'h0;
                        end
                        else
                        begin
                            n_cnt_reg <= n_cnt_reg + 11'h001;
                            state_reg <= ST_SAMPLE;
                        end
                    end
                ST_CORRECT:
                    if (extra_reg != 4'h0)
                        extra_reg <= extra_reg - 4'h1;
                    else if (conv_lo_act_reg[CONV_FREE])
                    begin
                        state_reg <= ST_SAMPLE;
                        n_cnt_reg <= 11'h000;
                        acc_reg <= 22'h000000;
                    end
                    else
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // averaging, optional gain and offset trim, then formatting
    always_comb
    begin
        avg16 = 16'((acc_reg >> avg_reg[AVG_SHIFT_LSB +: 3]));
        diff_s = $signed({2'b00, avg16})
                 - $signed({{6{offset_corr_i[11]}}, offset_corr_i});
        prod_s = diff_s * $signed({1'b0, gain_corr_i});
        scaled_s = prod_s >>> GAIN_FRAC;
        if (!conv_lo_act_reg[CONV_CORR])
            corr16 = avg16;
        else if (scaled_s < 0)
            corr16 = 16'h0000;
        else if (scaled_s > 31'sh0000FFFF)
            corr16 = 16'hFFFF;
        else
            corr16 = scaled_s[15:0];
        unique case (conv_lo_act_reg[CONV_RES_LSB +: 2])
            RES_16: fmt16 = corr16;
            RES_10: fmt16 = conv_lo_act_reg[CONV_LEFT] ?
                {corr16[11:2], 6'h00} : {6'h00, corr16[11:2]};
            RES_8: fmt16 = conv_lo_act_reg[CONV_LEFT] ?
                {corr16[11:4], 8'h00} : {8'h00, corr16[11:4]};
            default: fmt16 = conv_lo_act_reg[CONV_LEFT] ?
                {corr16[11:0], 4'h0} : {4'h0, corr16[11:0]};
        endcase
    end

    // result register and its one-cycle valid pulse
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            result_o <= 16'h0000;
            result_valid_o <= 1'b0;
        end
        else if (running && state_reg == ST_CORRECT && extra_reg == 4'h0)
        begin
            result_o <= fmt16;
            result_valid_o <= 1'b1;
        end
        else
            result_valid_o <= 1'b0;
    end

    // conversion request to the core, pulsed as sampling ends
    always_ff @(posedge sys_clk_i)
    begin
        if (clr || !running)
            conv_start_o <= 1'b0;
        else
            conv_start_o <= state_reg == ST_SAMPLE && htick
                            && samp_cnt_reg == samp_reg[5:0];
    end

    // core configuration: differential and resolution follow the synced copies, reference fields come straight from ref_reg
    always_comb
    begin
        core_cfg_o.ref_sel = ref_reg[REF_SEL_LSB +: 4];
        core_cfg_o.ref_comp = ref_reg[REF_COMP];
        core_cfg_o.differential = conv_lo_act_reg[CONV_DIFF];
        core_cfg_o.resolution = conv_lo_act_reg[CONV_RES_LSB +: 2];
        sync_busy_o = busy;
        enabled_o = enable_act_reg;
        sample_o = state_reg == ST_SAMPLE;
    end

    sequence s_sync_run;
        sync_busy_o [*3];
    endsequence

    // soft reset bit stands through the handover, then all is cleared
    sequence s_soft_reset_bit_run;
        soft_reset_bit_reg ##3 !soft_reset_bit_reg && !enable_reg && samp_reg == REG_RESET;
    endsequence

    AST_SYNC_SET: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        sync_start |=> s_sync_run)
        else $error("sync busy not held after synced write");
    AST_ENABLE_APPLY: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        gen_wr && wr_hit(ew, OFF_MAIN) |=> ##3 (enabled_o == enable_reg))
        else $error("enable not applied after sync");
    AST_PROT: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        prot_lock_i && !soft_clear |=> $stable(ref_reg))
        else $error("locked register changed");
    AST_RSVD: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        bus_i.rd && bus_i.addr == OFF_MAIN |=> rdata_o[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    AST_SOFT_RESET_BIT: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        soft_reset_bit_wr |=> s_soft_reset_bit_run)
        else $error("soft reset did not clear registers");
    AST_SOFT_RESET_BIT_DISC: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        soft_reset_bit_wr |=> $stable(ref_reg) && $stable(avg_reg))
        else $error("soft reset write changed other fields");
    AST_HALT: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        stby_reg && !run_stby_reg |=> state_reg == ST_IDLE)
        else $error("converter ran in standby");
    AST_ENPROT: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        enable_reg && !soft_clear |=> $stable(conv_lo_reg))
        else $error("protected register written while enabled");
    AST_ALIGN: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        result_valid_o && conv_lo_act_reg[CONV_LEFT]
        && conv_lo_act_reg[CONV_RES_LSB +: 2] == RES_12
        |-> result_o[3:0] == 4'h0)
        else $error("left aligned result low nibble set");
    AST_HOLD: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        take |-> ##[1:8] rel)
        else $error("held write never released");
endmodule : adcc_ctrl

// file: rtl/adcc_pkg.sv
package adcc_pkg;
    // register byte addresses
    localparam logic [5:0] OFF_MAIN = 6'h00;
    localparam logic [5:0] OFF_REF = 6'h01;
    localparam logic [5:0] OFF_AVG = 6'h02;
    localparam logic [5:0] OFF_SAMP = 6'h03;
    localparam logic [5:0] OFF_CONV_LO = 6'h04;
    localparam logic [5:0] OFF_CONV_HI = 6'h05;
    localparam logic [5:0] OFF_STATUS = 6'h19;
    // field positions
    localparam int MAIN_SOFT_RESET_BIT = 0;
    localparam int MAIN_ENABLE = 1;
    localparam int MAIN_RUNSTBY = 2;
    localparam int REF_COMP = 7;
    localparam int REF_SEL_LSB = 0;
    localparam int AVG_SHIFT_LSB = 4;
    localparam int AVG_NUM_LSB = 0;
    localparam int CONV_DIFF = 0;
    localparam int CONV_LEFT = 1;
    localparam int CONV_FREE = 2;
    localparam int CONV_CORR = 3;
    localparam int CONV_RES_LSB = 4;
    localparam int STATUS_BUSY = 7;
    // writable-bit masks, reserved bits stay zero
    localparam logic [7:0] MAIN_MASK = 8'h07;
    localparam logic [7:0] REF_MASK = 8'h8F;
    localparam logic [7:0] AVG_MASK = 8'h7F;
    localparam logic [7:0] SAMP_MASK = 8'h3F;
    localparam logic [7:0] CONV_LO_MASK = 8'h3F;
    localparam logic [7:0] CONV_HI_MASK = 8'h07;
    localparam logic [7:0] REG_RESET = 8'h00;
    // limits and encodings
    localparam logic [3:0] AVG_NUM_MAX = 4'hA;
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_16 = 2'h1;
    localparam logic [1:0] RES_10 = 2'h2;
    localparam logic [1:0] RES_8 = 2'h3;
    localparam logic [1:0] SZ_8 = 2'h0;
    localparam logic [1:0] SZ_16 = 2'h1;
    localparam logic [1:0] SZ_32 = 2'h2;
    // timing
    localparam logic [2:0] SYNC_CYCLES = 3'h3;
    localparam logic [8:0] PRESC_BASE = 9'h004;
    localparam logic [8:0] HALF_BASE = 9'h002;
    localparam int GAIN_FRAC = 11;

    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic [1:0] size;
        logic wr;
        logic rd;
    } adcc_bus_req_t;

    typedef struct packed {
        logic [3:0] ref_sel;
        logic ref_comp;
        logic differential;
        logic [1:0] resolution;
    } adcc_core_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_CORRECT = 4'b1000
    } adcc_state_t;
endpackage : adcc_pkg

// file: verif/adcc_core_model.sv
`timescale 1ns/10ps
module adcc_core_model
    import adcc_pkg::*;
#(
    parameter int LAT = 3
)
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic conv_start_i,
    input wire logic [11:0] value_i,
    output logic conv_done_o,
    output logic [11:0] conv_data_o
);
    int cnt;

    // one conversion per start pulse, answered after a fixed latency;
    // outside the done cycle the data bus toggles so stale values never match
    always_ff @(posedge sys_clk_i)
    begin
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o;
        if (!resetn_i)
        begin
            cnt <= 0;
            conv_data_o <= 12'h000;
        end
        else if (conv_start_i)
        begin
            cnt <= LAT;
        end
        else if (cnt == 1)
        begin
            cnt <= 0;
            conv_done_o <= 1'b1;
            conv_data_o <= value_i;
        end
        else if (cnt > 1)
        begin
            cnt <= cnt - 1;
        end
    end
endmodule : adcc_core_model

// file: verif/test_adcc_ctrl.sv
`timescale 1ns/10ps
module test_adcc_ctrl;
    import adcc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    adcc_bus_req_t bus = '0;
    logic [31:0] rdata;
    logic prot_lock = 1'b0;
    logic standby = 1'b0;
    logic start = 1'b0;
    logic done;
    logic [11:0] cdata;
    logic busy, enabled, sample, cstart, rvalid;
    adcc_core_cfg_t cfg;
    logic [15:0] result;
    logic [11:0] value = 12'h123;
    logic [11:0] gain = 12'h800;
    logic [11:0] offs = 12'h000;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    adcc_ctrl dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus),
        .rdata_o(rdata), .prot_lock_i(prot_lock), .standby_i(standby),
        .start_i(start), .conv_done_i(done), .conv_data_i(cdata),
        .gain_corr_i(gain), .offset_corr_i(offs),
        .sync_busy_o(busy), .enabled_o(enabled), .sample_o(sample),
        .conv_start_o(cstart), .core_cfg_o(cfg), .result_o(result),
        .result_valid_o(rvalid));
    adcc_core_model core (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .conv_start_i(cstart), .value_i(value), .conv_done_o(done),
        .conv_data_o(cdata));

    // 25 MHz clock and a run-length ceiling
    always #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] sz);
        @(posedge sys_clk_i);
        bus <= '{addr: a, wdata: d, size: sz, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        bus.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [1:0] sz,
                      input logic [31:0] exp, input string name);
        logic [31:0] m;
        m = (sz == SZ_8) ? 32'h0000_00FF : (sz == SZ_16) ? 32'h0000_FFFF
            : 32'hFFFF_FFFF;
        @(posedge sys_clk_i);
        bus <= '{addr: a, wdata: 32'h0, size: sz, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        bus.rd <= 1'b0;
        #1;
        chk(name, exp & m, rdata & m);
    endtask : rd

    // bounded wait for synchronisation to finish
    task automatic sync_wait();
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 20)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("sync_busy", 32'h0, {31'h0, busy});
    endtask : sync_wait

    task automatic pulse_start();
        @(posedge sys_clk_i);
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
    endtask : pulse_start

    // valid is part of the compare so a missing result cannot pass
    task automatic wait_result(input logic [15:0] exp, input string name);
        n = 0;
        #1;
        while (rvalid !== 1'b1 && n < 400)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk(name, {15'h0, 1'b1, exp}, {15'h0, rvalid, result});
    endtask : wait_result

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        // reset values, reserved bits and unmapped space
        rd(OFF_MAIN, SZ_32, 32'h0, "reset_0_3");
        rd(OFF_CONV_LO, SZ_16, 32'h0, "reset_conv");
        wr(OFF_REF, 32'hFF_FF_FF, SZ_32);
        rd(OFF_REF, SZ_32, 32'h0_3F_7F_8F, "masks");
        wr(OFF_CONV_LO, 32'hFFFF, SZ_16);
        sync_wait();
        rd(OFF_CONV_LO, SZ_16, 32'h07_3F, "conv_mask");
        rd(6'h10, SZ_8, 32'h0, "unmapped");
        $display("test registers done");
        // protection lock drops a write
        prot_lock <= 1'b1;
        wr(OFF_REF, 32'h05, SZ_8);
        prot_lock <= 1'b0;
        rd(OFF_REF, SZ_8, 32'h8F, "locked");
        // configuration reaches the core
        wr(OFF_REF, 32'h02_00_84, SZ_32);
        wr(OFF_CONV_LO, 32'h00_01, SZ_16);
        sync_wait();
        chk("cfg", 32'h4C, {24'h0, cfg});
        wr(OFF_CONV_LO, 32'h00_10, SZ_16);
        sync_wait();
        chk("cfg_res", 32'h49, {24'h0, cfg});
        wr(OFF_AVG, 32'h02_01, SZ_16);
        $display("test config done");
        // enable reads back at once, applies after sync
        wr(OFF_MAIN, 32'h02, SZ_8);
        rd(OFF_STATUS, SZ_8, 32'h80, "busy_set");
        rd(OFF_MAIN, SZ_8, 32'h02, "enable_rb");
        sync_wait();
        chk("enabled", 32'h1, {31'h0, enabled});
        wr(OFF_CONV_LO, 32'h00_04, SZ_16);
        rd(OFF_CONV_LO, SZ_16, 32'h00_10, "enable_prot");
        // two summed samples, no shift, 16-bit format
        pulse_start();
        #1;
        n = 0;
        while (sample !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        n = 0;
        while (sample === 1'b1 && n < 100)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("sample_len", 32'h6, n);
        wait_result(16'h0246, "sum2");
        $display("test average done");
        // standby halts unless run-in-standby
        standby <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        pulse_start();
        n = 0;
        repeat (60)
        begin
            @(posedge sys_clk_i);
            #1;
            if (cstart === 1'b1 || sample === 1'b1)
                n++;
        end
        chk("halted", 32'h0, n);
        wr(OFF_MAIN, 32'h06, SZ_8);
        sync_wait();
        pulse_start();
        wait_result(16'h0246, "standby_run");
        standby <= 1'b0;
        $display("test standby done");
        // disable, then shift, left align and free run
        wr(OFF_MAIN, 32'h00, SZ_8);
        sync_wait();
        chk("disabled", 32'h0, {31'h0, enabled});
        wr(OFF_AVG, 32'h12, SZ_8);
        pulse_start();
        wr(OFF_CONV_LO, 32'h00_06, SZ_16);
        sync_wait();
        wr(OFF_MAIN, 32'h02, SZ_8);
        sync_wait();
        pulse_start();
        wait_result(16'h2460, "shift_left");
        @(posedge sys_clk_i);
        value <= 12'h0F0;
        wait_result(16'h1E00, "free_run");
        $display("test left free done");
        // soft reset wins over the other written byte
        wr(OFF_MAIN, 32'h03_03, SZ_16);
        rd(OFF_MAIN, SZ_8, 32'h03, "soft_reset_bit_rb");
        sync_wait();
        rd(OFF_MAIN, SZ_32, 32'h0, "soft_reset_bit_0_3");
        rd(OFF_CONV_LO, SZ_16, 32'h0, "soft_reset_bit_conv");
        chk("soft_reset_bit_en", 32'h0, {31'h0, enabled});
        wr(OFF_MAIN, 32'h00, SZ_8);
        rd(OFF_MAIN, SZ_8, 32'h0, "soft_reset_bit_zero");
        $display("test soft reset done");
        // gain one half, offset three: (0xF0 - 3) / 2, three extra cycles
        offs <= 12'h003;
        gain <= 12'h400;
        wr(OFF_CONV_LO, 32'h00_08, SZ_16);
        sync_wait();
        wr(OFF_MAIN, 32'h02, SZ_8);
        sync_wait();
        pulse_start();
        wait_result(16'h0076, "corrected");
        $display("test correction done");
        tally_and_finish();
    end
endmodule : test_adcc_ctrl
